// *** cso_setup_regs.sv ***
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps

// How it works
// - Each channel stores mean or rms flag
// - Mean change under DC coupling is refused
// - Range accepted only from unit's allowed set
// - High ratio sensor: 2.5 ratio picks set
// - Range read returns stored range value
// - Channel read gives auto, mean, range
// - Clear-all zeroes every output selection
// - Clear-all refused while disk or printer on
// - Efficiency selection 0..7, three formulas
// - Frequency selection 0..7, channels A..C
// - Ten integration values; tenth uses bit 0
// - Integration 1..6 per channel bits
// - Integration 7..9 channel sum bits
// - Two load factor values, channels, sums
// - Out of range selection value refused
// - Unavailable selection bits dropped without error
// - Selection reads return stored values in order
// - Coupling AC, DC or AC+DC per channel

module cso_setup_regs
    import cso_pkg::*;
(
    input wire logic sys_clk_i, // System clock, 20 MHz
    input wire logic rst_n_i, // Asynchronous reset, active low
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction, 1 = write
    input wire logic [31:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    input wire logic [5:0] ch_present_i, // Channel fitted, from pins
    input wire logic [2:0] freq_present_i, // Frequency input fitted, from pins
    output cso_pkg::cso_chan_s [CSO_NUM_CH-1:0] chan_cfg_o, // Channel setup
    output cso_pkg::cso_sel_s sel_o, // Output item selections
    output logic disk_on_o, // Disk output enabled
    output logic printer_on_o // Printer output enabled
);
    import cso_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cso_apb_state_e state_reg; // Bus phase tracker

    logic [8:0] pins_filt; // Filtered presence pins
    logic [5:0] ch_ok; // Channels usable
    logic [5:0] sum_ok; // Channel sums usable
    logic [2:0] freq_ok; // Frequency inputs usable

    cso_unit_e unit_reg; // Fitted input unit
    logic [7:0] ratio_reg; // Sensor ratio times ten

    logic err_reg; // Sticky execution error
    logic exec_reg; // Pending write refused for content

    logic setup_cyc; // Setup phase of a transfer
    logic commit; // Accepted write at its ready edge

    logic [31:0] rd_val; // Read mux
    logic map_ok; // Address is mapped for this direction
    logic exec_bad; // Write content is illegal

    logic [2:0] ch_idx; // Channel word index
    logic [3:0] int_idx; // Integration word index
    cso_chan_s wr_chan; // Channel word as written
    logic [7:0] a8; // Low address byte

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Range must sit in the set of the fitted unit
    function automatic logic range_ok(input cso_unit_e u, input logic [7:0] ratio,
                                      input logic [15:0] r);
        int row;
        logic hit;

        row = CSO_NUM_ROWS;
        hit = 1'b0;
        case (u)
            UNIT_DIRECT: row = 0;
            UNIT_CLAMP20: row = 1;
            UNIT_CLAMP_HIGH: row = (ratio == CSO_RATIO_HIGH) ? 2 : 1;
            UNIT_CLAMP200: row = 3;
            UNIT_CLAMP500: row = 4;
            default: row = CSO_NUM_ROWS;
        endcase

        for (int k = 0; k < 8; k++) begin
            if (row < CSO_NUM_ROWS && r != 16'h0000 && CSO_RANGE_TAB[row][k] == r) begin
                hit = 1'b1;
            end
        end

        return hit;
    endfunction

    // Sums 12, 34, 56, 123, 456, 45 need all member channels
    function automatic logic [5:0] sums_of(input logic [5:0] p);
        return {p[3] & p[4], p[3] & p[4] & p[5], p[0] & p[1] & p[2],
                p[4] & p[5], p[2] & p[3], p[0] & p[1]};
    endfunction

    // Word lies inside a block of consecutive registers
    function automatic logic in_block(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------
    // Presence pins
    // ------------------------------------------------------------
    cso_pin_sync #(
        .W(9)
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i({freq_present_i, ch_present_i}),
        .filt_o(pins_filt)
    );

    assign ch_ok = pins_filt[5:0];
    assign freq_ok = pins_filt[8:6];

    // A sum counts only when all its channels are fitted
    assign sum_ok = sums_of(ch_ok);

    // ------------------------------------------------------------
    // Address decode and write checks
    // ------------------------------------------------------------
    assign a8 = paddr_i[7:0];
    assign ch_idx = paddr_i[4:2];
    assign int_idx = 4'(paddr_i[7:2] - CSO_OFF_INTEG0[7:2]);
    assign wr_chan = cso_chan_s'({pwdata_i[CH_CPL_LSB+:2], pwdata_i[CH_AUTO_BIT],
                                  pwdata_i[CH_MEAN_BIT], pwdata_i[CH_RANGE_LSB+:16]});

    // Upper address bits and byte offset must be clear
    always_comb begin
        rd_val = 32'h0000_0000;
        map_ok = (paddr_i[31:8] == 24'h00_0000) && (paddr_i[1:0] == 2'b00);
        exec_bad = 1'b0;
        if (!map_ok) begin
            map_ok = 1'b0;
        end else if (in_block(a8, CSO_OFF_CH0, CSO_OFF_CH_LAST)) begin
            // Auto, mean and range in one word, in that order
            rd_val[CH_RANGE_LSB+:16] = chan_cfg_o[ch_idx].range_ca;
            rd_val[CH_MEAN_BIT] = chan_cfg_o[ch_idx].mean_rect;
            rd_val[CH_AUTO_BIT] = chan_cfg_o[ch_idx].auto_rng;
            rd_val[CH_CPL_LSB+:2] = chan_cfg_o[ch_idx].coupling;
            if (pwdata_i[CH_CPL_LSB+:2] == 2'b11) begin
                exec_bad = 1'b1;
            end else if (wr_chan.coupling == CPL_DC &&
                         wr_chan.mean_rect != chan_cfg_o[ch_idx].mean_rect) begin
                exec_bad = 1'b1;
            end else if (!range_ok(unit_reg, ratio_reg, wr_chan.range_ca)) begin
                exec_bad = 1'b1;
            end
        end else if (a8 == CSO_OFF_UNIT) begin
            rd_val[UNIT_TYPE_LSB+:3] = unit_reg;
            rd_val[UNIT_RATIO_LSB+:8] = ratio_reg;
            exec_bad = pwdata_i[UNIT_TYPE_LSB+:3] > UNIT_CLAMP500;
        end else if (a8 == CSO_OFF_OUTCTL) begin
            rd_val[OUT_DISK_BIT] = disk_on_o;
            rd_val[OUT_PRN_BIT] = printer_on_o;
        end else if (a8 == CSO_OFF_CLEAR) begin
            map_ok = pwrite_i; // Write only
            exec_bad = disk_on_o | printer_on_o;
        end else if (a8 == CSO_OFF_STATUS) begin
            rd_val[STAT_ERR_BIT] = err_reg;
        end else if (a8 == CSO_OFF_EFF) begin
            rd_val[2:0] = sel_o.eff;
            exec_bad = pwdata_i > CSO_SEL3_MAX;
        end else if (a8 == CSO_OFF_FREQ) begin
            rd_val[2:0] = sel_o.freq;
            exec_bad = pwdata_i > CSO_SEL3_MAX;
        end else if (in_block(a8, CSO_OFF_INTEG0, CSO_OFF_INTEG_LAST)) begin
            rd_val[5:0] = sel_o.integ[int_idx];
            exec_bad = pwdata_i > CSO_SEL6_MAX;
        end else if (a8 == CSO_OFF_LOAD0 || a8 == CSO_OFF_LOAD1) begin
            rd_val[5:0] = sel_o.load[paddr_i[2]];
            exec_bad = pwdata_i > CSO_SEL6_MAX;
        end else begin
            map_ok = 1'b0;
        end

        if (!pwrite_i) begin
            exec_bad = 1'b0; // Reads never raise an execution error
        end
    end

    // ------------------------------------------------------------
    // APB phase tracking
    // ------------------------------------------------------------
    assign setup_cyc = psel_i & ~penable_i;

    assign commit = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

    // Zero wait states: ready rises in the first access cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            pready_o <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (setup_cyc) begin
                        state_reg <= ST_ACCESS;
                        pready_o <= 1'b1;
                    end
                end

                ST_ACCESS: begin
                    // Transfer ends here; a new setup may follow at once
                    state_reg <= ST_IDLE;
                    pready_o <= 1'b0;
                end

                default: begin
                    state_reg <= ST_IDLE;
                    pready_o <= 1'b0;
                end
            endcase
        end
    end

    // Answer is fixed in the setup cycle and held through access
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            exec_reg <= 1'b0;
        end else if (setup_cyc && state_reg == ST_IDLE) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
            pslverr_o <= ~map_ok | exec_bad;
            exec_reg <= map_ok & exec_bad;
        end else if (state_reg == ST_ACCESS) begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            exec_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status: sticky execution error, write one to clear
    // ------------------------------------------------------------

    // A new error in the clearing cycle wins over the clear
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_reg <= 1'b0;
        end else if (pready_o && exec_reg) begin
            err_reg <= 1'b1;
        end else if (commit && a8 == CSO_OFF_STATUS && pwdata_i[STAT_ERR_BIT]) begin
            err_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channel setup
    // ------------------------------------------------------------

    // Whole word is refused when any field is illegal, so a bad
    // range never drags a coupling change in with it
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < CSO_NUM_CH; i++) begin
                chan_cfg_o[i].coupling <= CPL_AC;
                chan_cfg_o[i].auto_rng <= 1'b0;
                chan_cfg_o[i].mean_rect <= 1'b0;
                chan_cfg_o[i].range_ca <= CSO_RANGE_RST;
            end
        end else if (commit && in_block(a8, CSO_OFF_CH0, CSO_OFF_CH_LAST)) begin
            chan_cfg_o[ch_idx] <= wr_chan;
        end
    end

    // Unit and ratio; stored ranges are not rechecked on a change
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unit_reg <= UNIT_DIRECT;
            ratio_reg <= CSO_RATIO_RST;
        end else if (commit && a8 == CSO_OFF_UNIT) begin
            unit_reg <= cso_unit_e'(pwdata_i[UNIT_TYPE_LSB+:3]);
            ratio_reg <= pwdata_i[UNIT_RATIO_LSB+:8];
        end
    end

    // ------------------------------------------------------------
    // Output enables
    // ------------------------------------------------------------

    // Levels for the disk and printer writers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            disk_on_o <= 1'b0;
            printer_on_o <= 1'b0;
        end else if (commit && a8 == CSO_OFF_OUTCTL) begin
            disk_on_o <= pwdata_i[OUT_DISK_BIT];
            printer_on_o <= pwdata_i[OUT_PRN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Output item selections
    // ------------------------------------------------------------

    // Bits for absent channels or sums are dropped on the way in,
    // so a later read shows what will really be output
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_o <= '0;
        end else if (commit) begin
            if (a8 == CSO_OFF_CLEAR) begin
                sel_o <= '0;
            end else if (a8 == CSO_OFF_EFF) begin
                sel_o.eff <= pwdata_i[2:0];
            end else if (a8 == CSO_OFF_FREQ) begin
                sel_o.freq <= pwdata_i[2:0] & freq_ok;
            end else if (in_block(a8, CSO_OFF_INTEG0, CSO_OFF_INTEG_LAST)) begin
                if (int_idx < 4'h6) begin
                    sel_o.integ[int_idx] <= pwdata_i[5:0] & ch_ok;
                end else if (int_idx < 4'h9) begin
                    sel_o.integ[int_idx] <= pwdata_i[5:0] & sum_ok;
                end else begin
                    sel_o.integ[int_idx] <= {5'h00, pwdata_i[0]};
                end
            end else if (a8 == CSO_OFF_LOAD0) begin
                sel_o.load[0] <= pwdata_i[5:0] & ch_ok;
            end else if (a8 == CSO_OFF_LOAD1) begin
                sel_o.load[1] <= pwdata_i[5:0] & sum_ok;
            end
        end
    end

endmodule

// *** cso_pkg.sv ***
package cso_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CSO_NUM_CH = 6; // Input channels
    localparam int CSO_NUM_INTEG = 10; // Integration selection values
    localparam int CSO_NUM_LOAD = 2; // Load factor selection values

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CSO_OFF_CH0 = 8'h00; // Channel 1 setup, then one word each
    localparam logic [7:0] CSO_OFF_CH_LAST = 8'h14; // Channel 6 setup
    localparam logic [7:0] CSO_OFF_UNIT = 8'h18; // Fitted unit and sensor ratio
    localparam logic [7:0] CSO_OFF_OUTCTL = 8'h1c; // Disk and printer output enables
    localparam logic [7:0] CSO_OFF_CLEAR = 8'h20; // Clear all selections (write only)
    localparam logic [7:0] CSO_OFF_STATUS = 8'h24; // Sticky execution error
    localparam logic [7:0] CSO_OFF_EFF = 8'h28; // Efficiency selection
    localparam logic [7:0] CSO_OFF_FREQ = 8'h2c; // Frequency selection
    localparam logic [7:0] CSO_OFF_INTEG0 = 8'h30; // Integration value 1
    localparam logic [7:0] CSO_OFF_INTEG_LAST = 8'h54; // Integration value 10
    localparam logic [7:0] CSO_OFF_LOAD0 = 8'h58; // Load factor value 1
    localparam logic [7:0] CSO_OFF_LOAD1 = 8'h5c; // Load factor value 2

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CH_RANGE_LSB = 0; // Range in units of 10 mA, 16 bits
    localparam int CH_MEAN_BIT = 16; // Rectifier type, 1 = mean
    localparam int CH_AUTO_BIT = 17; // Auto ranging flag
    localparam int CH_CPL_LSB = 24; // Coupling, 2 bits
    localparam int UNIT_TYPE_LSB = 0; // Unit type, 3 bits
    localparam int UNIT_RATIO_LSB = 8; // Sensor ratio times ten, 8 bits
    localparam int OUT_DISK_BIT = 0; // Disk output on
    localparam int OUT_PRN_BIT = 1; // Printer output on
    localparam int STAT_ERR_BIT = 0; // Execution error seen

    // ------------------------------------------------------------
    // Value limits and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CSO_SEL3_MAX = 32'h0000_0007; // Efficiency, frequency
    localparam logic [31:0] CSO_SEL6_MAX = 32'h0000_003f; // Integration, load factor
    localparam logic [7:0] CSO_RATIO_HIGH = 8'h19; // Ratio 2.5 times ten
    localparam logic [7:0] CSO_RATIO_RST = 8'h0a; // Ratio 1.0 times ten
    localparam logic [15:0] CSO_RANGE_RST = 16'h1388; // 50 A

    // ------------------------------------------------------------
    // Allowed ranges, 10 mA units, zero marks an empty slot
    // ------------------------------------------------------------
    localparam int CSO_NUM_ROWS = 5;
    localparam logic [15:0] CSO_RANGE_TAB [CSO_NUM_ROWS][8] = '{
        '{16'h0014, 16'h0032, 16'h0064, 16'h00c8, 16'h01f4, 16'h03e8, 16'h07d0, 16'h1388},
        '{16'h0032, 16'h0064, 16'h00c8, 16'h01f4, 16'h03e8, 16'h07d0, 16'h0000, 16'h0000},
        '{16'h007d, 16'h00fa, 16'h01f4, 16'h04e2, 16'h09c4, 16'h1388, 16'h0000, 16'h0000},
        '{16'h01f4, 16'h03e8, 16'h07d0, 16'h1388, 16'h2710, 16'h4e20, 16'h0000, 16'h0000},
        '{16'h03e8, 16'h07d0, 16'h1388, 16'h2710, 16'h4e20, 16'hc350, 16'h0000, 16'h0000}
    };

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CPL_AC = 2'b00,
        CPL_DC = 2'b01,
        CPL_ACDC = 2'b10
    } cso_coupling_e;

    typedef enum logic [2:0] {
        UNIT_DIRECT = 3'b000,
        UNIT_CLAMP20 = 3'b001,
        UNIT_CLAMP_HIGH = 3'b010,
        UNIT_CLAMP200 = 3'b011,
        UNIT_CLAMP500 = 3'b100
    } cso_unit_e;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ACCESS = 1'b1
    } cso_apb_state_e;

    typedef struct packed {
        cso_coupling_e coupling; // Input coupling
        logic auto_rng; // Auto ranging on
        logic mean_rect; // 1 = mean rectified, 0 = true rms
        logic [15:0] range_ca; // Current range, 10 mA units
    } cso_chan_s;

    typedef struct packed {
        logic [2:0] eff; // Efficiency formulas 3..1
        logic [2:0] freq; // Frequency channels C..A
        logic [CSO_NUM_INTEG-1:0][5:0] integ; // Integration values
        logic [CSO_NUM_LOAD-1:0][5:0] load; // Load factor values
    } cso_sel_s;

endpackage

// *** cso_pin_sync.sv ***
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Three stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module cso_pin_sync #(
    parameter int W = 9 // Number of pins
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_n_i, // Asynchronous reset, active low
    input wire logic [W-1:0] pin_i, // Raw pins
    output logic [W-1:0] filt_o // Filtered level
);

    logic [W-1:0] s1_reg; // First stage, read only by s2
    logic [W-1:0] s2_reg; // Second stage
    logic [W-1:0] s3_reg; // Third stage

    // Shift chain
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A bit moves only once two later stages agree, which hides
    // a single metastable sample from the logic downstream
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    filt_o[g] <= 1'b0;
                end else if (s2_reg[g] == s3_reg[g]) begin
                    filt_o[g] <= s3_reg[g];
                end
            end
        end
    endgenerate

endmodule

// *** cso_setup_regs_sva.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// Port checker for the setup register block
// ------------------------------------------------
module cso_setup_regs_sva
    import cso_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic psel_i, // Select
    input wire logic penable_i, // Enable
    input wire logic pwrite_i, // Direction
    input wire logic [31:0] paddr_i, // Address
    input wire logic [31:0] pwdata_i, // Write data
    input wire logic [31:0] prdata_o, // Read data
    input wire logic pready_o, // Ready
    input wire logic pslverr_o, // Error
    input cso_pkg::cso_chan_s [CSO_NUM_CH-1:0] chan_cfg_o, // Channels
    input cso_pkg::cso_sel_s sel_o, // Selections
    input wire logic disk_on_o, // Disk on
    input wire logic printer_on_o // Printer on
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Setup phase and a completed write to one word
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence wr_s(logic [7:0] a);
        psel_i && penable_i && pwrite_i && pready_o && paddr_i == {24'h0, a};
    endsequence
    rdy_timing_a: assert property (setup_s |=> pready_o) else $error("late ready");
    rdy_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
    err_rdy_a: assert property (pslverr_o |-> pready_o) else $error("lone error");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stale data");
    clear_zero_a: assert property (wr_s(CSO_OFF_CLEAR) ##0 !disk_on_o && !printer_on_o
        |=> sel_o == '0) else $error("clear kept items");
    clear_busy_a: assert property (wr_s(CSO_OFF_CLEAR) ##0 (disk_on_o || printer_on_o)
        |-> pslverr_o ##1 $stable(sel_o)) else $error("clear while busy");
    eff_range_a: assert property (wr_s(CSO_OFF_EFF) ##0 pwdata_i > CSO_SEL3_MAX
        |-> pslverr_o ##1 $stable(sel_o.eff)) else $error("big value kept");
    dc_mean_a: assert property (wr_s(CSO_OFF_CH0) ##0 pwdata_i[25:24] == 2'b01
        && pwdata_i[16] != chan_cfg_o[0].mean_rect |-> pslverr_o) else $error("dc mean");
    integ_top_a: assert property (sel_o.integ[9][5:1] == 5'h0) else $error("time bits");
endmodule

bind cso_setup_regs cso_setup_regs_sva chk_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .chan_cfg_o(chan_cfg_o), .sel_o(sel_o), .disk_on_o(disk_on_o),
    .printer_on_o(printer_on_o));

// *** cso_host.sv ***
`timescale 1ns/100ps
// ------------------------------------------------
// Remote host model, speaks APB to the block
// ------------------------------------------------
module cso_host (
    input wire logic sys_clk_i, // Clock
    input wire logic pready_i, // Ready
    input wire logic pslverr_i, // Error
    input wire logic [31:0] prdata_i, // Read data
    output logic psel_o, // Select
    output logic penable_o, // Enable
    output logic pwrite_o, // Direction
    output logic [31:0] paddr_o, // Address
    output logic [31:0] pwdata_o // Write data
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 32'h0;
        pwdata_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        // Hold until ready; the bench timeout cuts a hang
        do begin
            @(posedge sys_clk_i);
        end while (pready_i !== 1'b1);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o <= ~d; // Released data goes stale
        @(posedge sys_clk_i);
    endtask
endmodule

// *** tb_cso_setup_regs.sv ***
`timescale 1ns/100ps
module tb_cso_setup_regs;
    import cso_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic [5:0] ch_pres = 6'h3f; // All channels fitted
    logic [2:0] freq_pres = 3'b011; // Input C missing
    cso_chan_s [CSO_NUM_CH-1:0] chan_cfg;
    cso_sel_s sel;
    logic disk, prn;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    cso_setup_regs dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ch_present_i(ch_pres),
        .freq_present_i(freq_pres), .chan_cfg_o(chan_cfg), .sel_o(sel), .disk_on_o(disk),
        .printer_on_o(prn));
    cso_host host_u (.sys_clk_i(sys_clk_i), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b1, {24'h0, a}, d, r, e);
        chk("write error", {31'h0, ee}, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b0, {24'h0, a}, 32'h0, r, e);
        chk("read error", 32'h0, {31'h0, e});
        chk("read data", x, r);
    endtask
    // Range set of the direct unit, refusal flags the sticky error
    task automatic t_range;
        rd(CSO_OFF_CH0, 32'h0000_1388);
        wr(CSO_OFF_CH0, 32'h0000_0014, 1'b0);
        wr(CSO_OFF_CH0, 32'h0000_0015, 1'b1);
        rd(CSO_OFF_CH0, 32'h0000_0014);
        rd(CSO_OFF_STATUS, 32'h1);
        wr(CSO_OFF_STATUS, 32'h1, 1'b0);
        wr(8'h60, 32'h0, 1'b1);
        rd(CSO_OFF_STATUS, 32'h0);
    endtask
    // Rectifier flag against coupling
    task automatic t_mean;
        wr(CSO_OFF_CH0, 32'h0001_0014, 1'b0);
        wr(CSO_OFF_CH0, 32'h0100_0014, 1'b1);
        wr(CSO_OFF_CH0, 32'h0101_0014, 1'b0);
        wr(CSO_OFF_CH0, 32'h0301_0014, 1'b1);
        rd(CSO_OFF_CH0, 32'h0101_0014);
        wr(CSO_OFF_CH_LAST, 32'h0201_1388, 1'b0);
        rd(CSO_OFF_CH_LAST, 32'h0201_1388);
    endtask
    // High ratio clamp: the ratio picks the set
    task automatic t_clamp;
        wr(CSO_OFF_UNIT, 32'h0000_1902, 1'b0);
        wr(8'h04, 32'h0000_007d, 1'b0);
        wr(CSO_OFF_UNIT, 32'h0000_0a02, 1'b0);
        wr(8'h04, 32'h0000_007d, 1'b1);
        wr(8'h04, 32'h0000_0032, 1'b0);
        rd(8'h04, 32'h0000_0032);
    endtask
    // Selection values, limits and masking
    task automatic t_sel;
        ch_pres <= 6'h3e; // Channel 1 gone
        wr(CSO_OFF_EFF, 32'h7, 1'b0);
        wr(CSO_OFF_EFF, 32'h8, 1'b1);
        rd(CSO_OFF_EFF, 32'h7);
        wr(CSO_OFF_FREQ, 32'h7, 1'b0);
        rd(CSO_OFF_FREQ, 32'h3);
        for (int i = 0; i < CSO_NUM_INTEG; i++) begin
            wr(CSO_OFF_INTEG0 + 8'(4 * i), 32'h3f, 1'b0);
            rd(CSO_OFF_INTEG0 + 8'(4 * i), (i == 9) ? 32'h1 : (i > 5) ? 32'h36 : 32'h3e);
        end
        wr(CSO_OFF_INTEG_LAST, 32'h40, 1'b1);
        rd(CSO_OFF_INTEG_LAST, 32'h1);
        wr(CSO_OFF_LOAD0, 32'h3f, 1'b0);
        wr(CSO_OFF_LOAD1, 32'h2a, 1'b0);
        rd(CSO_OFF_LOAD1, 32'h22);
    endtask
    // Clear-all refused while an output runs
    task automatic t_clear;
        wr(CSO_OFF_OUTCTL, 32'h1, 1'b0);
        chk("out on", 32'h1, {30'h0, prn, disk});
        wr(CSO_OFF_CLEAR, 32'h0, 1'b1);
        wr(CSO_OFF_OUTCTL, 32'h2, 1'b0);
        wr(CSO_OFF_CLEAR, 32'h0, 1'b1);
        rd(CSO_OFF_EFF, 32'h7);
        wr(CSO_OFF_OUTCTL, 32'h0, 1'b0);
        wr(CSO_OFF_CLEAR, 32'h0, 1'b0);
        rd(CSO_OFF_EFF, 32'h0);
        rd(CSO_OFF_LOAD0, 32'h0);
        rd(CSO_OFF_INTEG_LAST, 32'h0);
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang limit
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        t_range();
        t_mean();
        t_clamp();
        t_sel();
        t_clear();
        final_report();
    end
endmodule
